// ==== tic_pkg.sv ====
// Shared constants, types and helpers of the dual-channel capture timer.
`default_nettype none
package tic_pkg;
    localparam int TIC_DW = 16;
    localparam int TIC_AW = 5;
    localparam int TIC_CW = 16;
    localparam int TIC_NCH = 2;
    localparam int TIC_NCAP = 4;
    localparam int TIC_NPIN = 8;
    localparam int TIC_NIRQ = 10;
    // Register word addresses.
    localparam logic [4:0] TIC_OFS_START = 5'h00;
    localparam logic [4:0] TIC_OFS_CTRL0 = 5'h01;
    localparam logic [4:0] TIC_OFS_CTRL1 = 5'h02;
    localparam logic [4:0] TIC_OFS_PINMODE = 5'h03;
    localparam logic [4:0] TIC_OFS_EDGE = 5'h04;
    localparam logic [4:0] TIC_OFS_GPIO_OUT = 5'h05;
    localparam logic [4:0] TIC_OFS_GPIO_DIR = 5'h06;
    localparam logic [4:0] TIC_OFS_GPIO_IN = 5'h07;
    localparam logic [4:0] TIC_OFS_OSC = 5'h08;
    localparam logic [4:0] TIC_OFS_IRQ_STAT = 5'h09;
    localparam logic [4:0] TIC_OFS_IRQ_MASK = 5'h0a;
    localparam logic [4:0] TIC_OFS_CNT0 = 5'h0b;
    localparam logic [4:0] TIC_OFS_CNT1 = 5'h0c;
    localparam logic [1:0] TIC_OFS_CAP_HI = 2'h2;
    // Field positions.
    localparam int TIC_START_RUN_LSB = 0;
    localparam int TIC_START_STOP_SEL_LSB = 2;
    localparam int TIC_CTRL_SRC_LSB = 0;
    localparam int TIC_CTRL_CLR_LSB = 5;
    localparam int TIC_PIN_EXT_MODE_BIT = 8;
    localparam int TIC_PIN_EXT_EDGE_LSB = 9;
    localparam int TIC_OSC_HIGH_BIT = 0;
    localparam int TIC_OSC_OPT_BIT = 1;
    localparam int TIC_IRQ_PER_CH = 5;
    localparam int TIC_IRQ_OVF_POS = 4;
    // Reset values.
    localparam logic [15:0] TIC_RST_REG = 16'h0000;
    localparam logic [15:0] TIC_RST_EDGE = 16'h0000;
    localparam logic [4:0] TIC_RST_PRESC = 5'h00;
    // Timing: count period in source ticks, prescaler length.
    localparam int TIC_COUNT_PERIOD = 65536;
    localparam int TIC_PRESC_LEN = 32;
    localparam int TIC_REF_MHZ = 40;
    localparam int TIC_SRC_MAX_MHZ = 64;

    typedef enum logic [2:0] {
        TIC_SRC_DIV1, TIC_SRC_DIV2, TIC_SRC_DIV4, TIC_SRC_DIV8,
        TIC_SRC_DIV32, TIC_SRC_EXT, TIC_SRC_HSOSC, TIC_SRC_NONE
    } tic_src_t;

    typedef enum logic [1:0] {
        TIC_EDGE_RISE, TIC_EDGE_FALL, TIC_EDGE_BOTH, TIC_EDGE_OFF
    } tic_edge_t;

    // Count-source tick for one channel in the current cycle.
    function automatic logic tic_src_tick(input tic_src_t sel,
                                          input logic [4:0] presc,
                                          input logic ext_tick,
                                          input logic hs_tick,
                                          input logic hs_allowed);
        logic t;
        t = 1'b0;
        case (sel)
            TIC_SRC_DIV1: t = 1'b1;
            TIC_SRC_DIV2: t = (presc[0] == 1'b0);
            TIC_SRC_DIV4: t = (presc[1:0] == 2'h0);
            TIC_SRC_DIV8: t = (presc[2:0] == 3'h0);
            TIC_SRC_DIV32: t = (presc == 5'h00);
            TIC_SRC_EXT: t = ext_tick;
            TIC_SRC_HSOSC: t = hs_allowed ? hs_tick : 1'b1;
            default: t = 1'b0;
        endcase
        return t;
    endfunction
endpackage
`default_nettype wire

// ==== tic_edge_det.sv ====
// Two-stage pin synchroniser with selectable active-edge detector.
`timescale 1ns/1ps
`default_nettype none
module tic_edge_det
    import tic_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Pin and edge choice
    input wire logic pin_in,
    input wire tic_pkg::tic_edge_t edge_sel_in,
    // Results
    output logic level_out,
    output logic edge_out
);
    logic meta;
    logic prev;
    wire rise = level_out & ~prev;
    wire fall = ~level_out & prev;

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            meta <= 1'b0;
            level_out <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            meta <= pin_in;
            level_out <= meta;
            prev <= level_out;
        end
    end

    assign edge_out = (edge_sel_in == TIC_EDGE_RISE) ? rise :
                      (edge_sel_in == TIC_EDGE_FALL) ? fall :
                      (edge_sel_in == TIC_EDGE_BOTH) ? (rise | fall) : 1'b0;

    AST_EDGE_RISE_ONLY: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        (edge_sel_in == TIC_EDGE_RISE && edge_out) |-> ($past(level_out) == 1'b0))
        else $error("Rising edge reported without a low level before.");
endmodule
`default_nettype wire

// ==== tic_channel.sv ====
// One 16-bit free-running up-counter with its four capture registers.
`timescale 1ns/1ps
`default_nettype none
module tic_channel
    import tic_pkg::*;
#(
    parameter int CW = TIC_CW,
    parameter int NCAP = TIC_NCAP
)
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Counting control
    input wire logic tick_in,
    input wire logic run_in,
    input wire logic [NCAP-1:0] cap_evt_in,
    // State
    output logic [CW-1:0] count_out,
    output logic [NCAP*CW-1:0] cap_flat_out,
    output logic ovf_out
);
    logic [CW-1:0] cap_q [NCAP];
    wire cnt_step = run_in & tick_in;
    wire [CW-1:0] next_count = count_out + 1'b1;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);

    // The all-ones to zero wrap is the overflow event.
    assign ovf_out = cnt_step & (count_out == {CW{1'b1}});

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
            count_out <= '0;
        else if (cnt_step)
            count_out <= next_count;
    end

    genvar i;
    generate
        for (i = 0; i < NCAP; i++)
        begin : g_cap
            always_ff @(posedge ref_clk_in)
            begin
                if (!rst_b_in)
                    cap_q[i] <= '0;
                else if (cap_evt_in[i])
                    cap_q[i] <= count_out;
            end
            assign cap_flat_out[i*CW +: CW] = cap_q[i];
        end
    endgenerate

    AST_WRAP_TO_ZERO: assert property (ovf_out |=> count_out == '0)
        else $error("Counter did not wrap to zero after overflow.");
    AST_FREE_RUN_STEP: assert property (cnt_step && !ovf_out
        |=> count_out == $past(count_out) + 1'b1)
        else $error("Counter did not advance by one on a tick.");
    AST_HOLD_NO_TICK: assert property (!cnt_step |=> $stable(count_out))
        else $error("Counter moved without a running tick.");
    AST_CAPTURE_VALUE: assert property (cap_evt_in[0]
        |=> cap_flat_out[CW-1:0] == $past(count_out))
        else $error("Capture register did not take the counter value.");
endmodule
`default_nettype wire

// ==== tic_top.sv ====
// Dual-channel 16-bit input-capture timer with register port and pins.
//
// Overview of operation
// - With clear select zero, each counter runs free over 65536 ticks.
// - Writing one to a channel's start bit starts its counter.
// - Writing zero stops the counter only when its stop select is one.
// - Capture edges and counter overflow raise the channel's interrupt.
// - Source: system clock /1,/2,/4,/8,/32, fast oscillator, or pin edge.
// - Fast oscillator source only when the option bit is one.
// - Internal fast clock is oscillator/2 at 64/48 MHz, else equal.
// - First capture pin serves as port, capture input or count clock.
// - The other seven pins are each port or capture input.
`timescale 1ns/1ps
`default_nettype none
module tic_top
    import tic_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Register port
    input wire logic [TIC_AW-1:0] reg_addr_in,
    input wire logic [TIC_DW-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [TIC_DW-1:0] reg_rdata_out,
    // Clock system
    input wire logic hs_osc_tick_in,
    input wire logic timer_clock_enable_in,
    input wire logic osc_select_option_in,
    output logic internal_high_tick_out,
    // Capture pins
    input wire logic [TIC_NPIN-1:0] capture_pin_in,
    output logic [TIC_NPIN-1:0] capture_pin_out,
    output logic [TIC_NPIN-1:0] capture_pin_oe_out,
    // Interrupt
    output logic irq_out
);
    ////////////////////////////////////////////////////////////////////////
    logic [TIC_NCH-1:0] run;
    logic [TIC_NCH-1:0] stop_sel;
    logic [15:0] ctrl [TIC_NCH];
    logic [15:0] pin_mode;
    logic [15:0] edge_cfg;
    logic [7:0] gpio_out;
    logic [7:0] gpio_dir;
    logic osc_high;
    logic [TIC_NIRQ-1:0] irq_stat;
    logic [TIC_NIRQ-1:0] irq_mask;
    logic [4:0] presc;
    logic ih_div;
    logic opt_meta;
    logic opt_sync;
    logic opt_done;
    logic hs_allowed;
    logic [TIC_NPIN-1:0] pin_level;
    logic [TIC_NPIN-1:0] pin_edge;
    logic ext_edge;
    logic [TIC_CW-1:0] count [TIC_NCH];
    logic [TIC_NCAP*TIC_CW-1:0] cap_flat [TIC_NCH];
    logic [TIC_NCH-1:0] ovf;
    logic [TIC_NCH-1:0] src_tick;
    logic [TIC_DW-1:0] next_rdata;

    ////////////////////////////////////////////////////////////////////////
    // Address decode.
    wire wr_start = reg_wr_in && reg_addr_in == TIC_OFS_START;
    wire wr_irq_stat = reg_wr_in && reg_addr_in == TIC_OFS_IRQ_STAT;
    wire ext_mode = pin_mode[TIC_PIN_EXT_MODE_BIT];
    wire tic_edge_t ext_edge_sel =
        tic_edge_t'(pin_mode[TIC_PIN_EXT_EDGE_LSB +: 2]);
    wire [TIC_NPIN-1:0] cap_en = pin_mode[TIC_NPIN-1:0] &
                                 {{(TIC_NPIN-1){1'b1}}, ~ext_mode};
    wire [TIC_NPIN-1:0] cap_evt = cap_en & pin_edge;
    wire ext_tick = ext_mode & ext_edge;
    wire [TIC_NIRQ-1:0] irq_evt = {ovf[1], cap_evt[7:4], ovf[0], cap_evt[3:0]};
    wire [TIC_NIRQ-1:0] next_irq_stat =
        (irq_stat & ~(wr_irq_stat ? reg_wdata_in[TIC_NIRQ-1:0] : '0)) |
        irq_evt;

    ////////////////////////////////////////////////////////////////////////
    // Synchroniser runs through reset; its settled value is held at release.
    always_ff @(posedge ref_clk_in)
    begin
        opt_meta <= osc_select_option_in;
        opt_sync <= opt_meta;
        if (!rst_b_in)
        begin
            opt_done <= 1'b0;
            hs_allowed <= 1'b0;
        end
        else
        begin
            opt_done <= 1'b1;
            if (opt_done == 1'b0)
                hs_allowed <= opt_sync;
        end
    end

    // Prescaler for the divided system clock, and fast-clock halving.
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            presc <= TIC_RST_PRESC;
            ih_div <= 1'b0;
        end
        else
        begin
            presc <= presc + 1'b1;
            if (hs_osc_tick_in)
                ih_div <= ~ih_div;
        end
    end

    assign internal_high_tick_out = hs_osc_tick_in & (~osc_high | ih_div);

    ////////////////////////////////////////////////////////////////////////
    // Register writes.
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            run <= '0;
            stop_sel <= '0;
            ctrl[0] <= TIC_RST_REG;
            ctrl[1] <= TIC_RST_REG;
            pin_mode <= TIC_RST_REG;
            edge_cfg <= TIC_RST_EDGE;
            gpio_out <= '0;
            gpio_dir <= '0;
            osc_high <= 1'b0;
            irq_mask <= '0;
            irq_stat <= '0;
        end
        else
        begin
            irq_stat <= next_irq_stat;
            if (wr_start)
            begin
                stop_sel <= reg_wdata_in[TIC_START_STOP_SEL_LSB +: TIC_NCH];
                for (int c = 0; c < TIC_NCH; c++)
                begin
                    if (reg_wdata_in[TIC_START_RUN_LSB + c])
                        run[c] <= 1'b1;
                    else if (reg_wdata_in[TIC_START_STOP_SEL_LSB + c])
                        run[c] <= 1'b0;
                end
            end
            if (reg_wr_in && reg_addr_in == TIC_OFS_CTRL0)
                ctrl[0] <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == TIC_OFS_CTRL1)
                ctrl[1] <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == TIC_OFS_PINMODE)
                pin_mode <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == TIC_OFS_EDGE)
                edge_cfg <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == TIC_OFS_GPIO_OUT)
                gpio_out <= reg_wdata_in[7:0];
            if (reg_wr_in && reg_addr_in == TIC_OFS_GPIO_DIR)
                gpio_dir <= reg_wdata_in[7:0];
            if (reg_wr_in && reg_addr_in == TIC_OFS_OSC)
                osc_high <= reg_wdata_in[TIC_OSC_HIGH_BIT];
            if (reg_wr_in && reg_addr_in == TIC_OFS_IRQ_MASK)
                irq_mask <= reg_wdata_in[TIC_NIRQ-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path; data stand one cycle after the read strobe.
    always_comb
    begin
        next_rdata = '0;
        if (reg_addr_in == TIC_OFS_START)
            next_rdata = {12'h000, stop_sel, run};
        else if (reg_addr_in == TIC_OFS_CTRL0)
            next_rdata = ctrl[0];
        else if (reg_addr_in == TIC_OFS_CTRL1)
            next_rdata = ctrl[1];
        else if (reg_addr_in == TIC_OFS_PINMODE)
            next_rdata = pin_mode;
        else if (reg_addr_in == TIC_OFS_EDGE)
            next_rdata = edge_cfg;
        else if (reg_addr_in == TIC_OFS_GPIO_OUT)
            next_rdata = {8'h00, gpio_out};
        else if (reg_addr_in == TIC_OFS_GPIO_DIR)
            next_rdata = {8'h00, gpio_dir};
        else if (reg_addr_in == TIC_OFS_GPIO_IN)
            next_rdata = {8'h00, pin_level};
        else if (reg_addr_in == TIC_OFS_OSC)
            next_rdata = {14'h0000, hs_allowed, osc_high};
        else if (reg_addr_in == TIC_OFS_IRQ_STAT)
            next_rdata = {6'h00, irq_stat};
        else if (reg_addr_in == TIC_OFS_IRQ_MASK)
            next_rdata = {6'h00, irq_mask};
        else if (reg_addr_in == TIC_OFS_CNT0)
            next_rdata = count[0];
        else if (reg_addr_in == TIC_OFS_CNT1)
            next_rdata = count[1];
        else if (reg_addr_in[4:3] == TIC_OFS_CAP_HI)
            next_rdata = cap_flat[reg_addr_in[2]][reg_addr_in[1:0]*TIC_CW +:
                                                  TIC_CW];
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
            reg_rdata_out <= '0;
        else if (reg_rd_in)
            reg_rdata_out <= next_rdata;
        else
            reg_rdata_out <= '0;
    end

    assign irq_out = |(irq_stat & irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // Pins: port mode drives from the output latch, capture mode listens.
    assign capture_pin_out = gpio_out;
    assign capture_pin_oe_out = gpio_dir & ~cap_en &
                                {{(TIC_NPIN-1){1'b1}}, ~ext_mode};

    genvar p;
    generate
        for (p = 0; p < TIC_NPIN; p++)
        begin : g_pin
            tic_edge_det u_det (
                .ref_clk_in(ref_clk_in),
                .rst_b_in(rst_b_in),
                .pin_in(capture_pin_in[p]),
                .edge_sel_in(tic_edge_t'(edge_cfg[2*p +: 2])),
                .level_out(pin_level[p]),
                .edge_out(pin_edge[p])
            );
        end
    endgenerate

    tic_edge_det u_ext_det (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .pin_in(capture_pin_in[0]),
        .edge_sel_in(ext_edge_sel),
        .level_out(),
        .edge_out(ext_edge)
    );

    ////////////////////////////////////////////////////////////////////////
    // Channels; counting needs the timer clock enable held by software.
    genvar c;
    generate
        for (c = 0; c < TIC_NCH; c++)
        begin : g_ch
            assign src_tick[c] = timer_clock_enable_in &
                tic_src_tick(tic_src_t'(ctrl[c][TIC_CTRL_SRC_LSB +: 3]),
                             presc, ext_tick, hs_osc_tick_in,
                             hs_allowed);
            tic_channel u_ch (
                .ref_clk_in(ref_clk_in),
                .rst_b_in(rst_b_in),
                .tick_in(src_tick[c]),
                .run_in(run[c]),
                .cap_evt_in(cap_evt[c*TIC_NCAP +: TIC_NCAP]),
                .count_out(count[c]),
                .cap_flat_out(cap_flat[c]),
                .ovf_out(ovf[c])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    sequence seq_start_write;
        wr_start && reg_wdata_in[TIC_START_RUN_LSB];
    endsequence
    sequence seq_stop_write;
        wr_start && !reg_wdata_in[TIC_START_RUN_LSB] &&
            reg_wdata_in[TIC_START_STOP_SEL_LSB];
    endsequence
    sequence seq_stop_ignored;
        wr_start && !reg_wdata_in[TIC_START_RUN_LSB] &&
            !reg_wdata_in[TIC_START_STOP_SEL_LSB] && run[0];
    endsequence

    AST_START_RUNS: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in) seq_start_write |=> run[0])
        else $error("Start write did not start channel zero.");
    AST_STOP_WITH_SEL: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in) seq_stop_write |=> !run[0])
        else $error("Stop write with stop select did not stop.");
    AST_STOP_IGNORED: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in) seq_stop_ignored |=> run[0])
        else $error("Zero write without stop select stopped the count.");
    AST_OVF_IRQ: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        ovf[0] && irq_mask[TIC_IRQ_OVF_POS] |=> irq_out[*2])
        else $error("Overflow did not raise a held interrupt.");
    AST_SET_WINS: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        cap_evt[0] && wr_irq_stat && reg_wdata_in[0] |=> irq_stat[0])
        else $error("Capture flag lost to a same-cycle clear.");
    AST_HS_FALLBACK: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        !hs_allowed && timer_clock_enable_in &&
        ctrl[0][2:0] == 3'h6 |-> src_tick[0])
        else $error("Oscillator source used without the option bit.");
    AST_IH_HALF: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        osc_high && internal_high_tick_out |=> !internal_high_tick_out)
        else $error("Internal fast clock not halved at high range.");
    AST_PIN_LISTENS: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        cap_en[1] || ext_mode |-> !capture_pin_oe_out[1] ||
        !cap_en[1])
        else $error("Capture pin driven while in capture mode.");
endmodule
`default_nettype wire

// ==== tic_far_end.sv ====
// Far-side model: capture pin drivers, fast oscillator and clock enable.
`timescale 1ns/1ps
`default_nettype none
module tic_far_end
(
    // Clock
    input wire logic ref_clk_in,
    // Requests from the bench
    input wire logic [7:0] lvl_in,
    input wire logic ext_clk_on_in,
    input wire logic clk_en_req_in,
    // Pin drive of the timer
    input wire logic [7:0] pin_out_in,
    input wire logic [7:0] pin_oe_in,
    // Far-side signals
    output logic [7:0] pin_level_out,
    output logic hs_tick_out,
    output logic clk_en_out
);
    logic [2:0] div = 3'h0;
    logic [7:0] drive;
    always @(posedge ref_clk_in) div <= div + 3'h1;
    // The timer clock enable follows the bench request with no delay here.
    assign clk_en_out = clk_en_req_in;
    assign hs_tick_out = div[0];
    // The external count clock has a period of eight cycles.
    assign drive = {lvl_in[7:1], ext_clk_on_in ? div[2] : lvl_in[0]};
    assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & drive);
endmodule
`default_nettype wire

// ==== tic_top_tb.sv ====
// Self-checking bench for the dual-channel capture timer.
`timescale 1ns/1ps
`default_nettype none
module tic_top_tb;
    import tic_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic opt = 1'b1;
    logic [7:0] lvl = 8'h00;
    logic ext_on = 1'b0;
    logic en_req = 1'b1;
    logic hs_tick, clk_en, ih_tick, irq;
    logic [7:0] pins, pout, poe;
    logic [15:0] rdata, v, a, c0v;
    int n_errors = 0;
    int n_checks = 0;
    int ih_cnt = 0;
    int i;
    always #12.5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) if (ih_tick) ih_cnt <= ih_cnt + 1;
    tic_top u_tic_top (
        .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .hs_osc_tick_in(hs_tick),
        .timer_clock_enable_in(clk_en), .osc_select_option_in(opt),
        .internal_high_tick_out(ih_tick), .capture_pin_in(pins),
        .capture_pin_out(pout), .capture_pin_oe_out(poe), .irq_out(irq));
    tic_far_end u_tic_far_end (
        .ref_clk_in(ref_clk_in), .lvl_in(lvl), .ext_clk_on_in(ext_on),
        .clk_en_req_in(en_req), .pin_out_in(pout), .pin_oe_in(poe),
        .pin_level_out(pins), .hs_tick_out(hs_tick), .clk_en_out(clk_en));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        if (n_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr_reg(input logic [4:0] ad, input logic [15:0] d);
        @(posedge ref_clk_in);
        addr <= ad;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [4:0] ad, output logic [15:0] d);
        @(posedge ref_clk_in);
        addr <= ad;
        rd <= 1'b1;
        @(posedge ref_clk_in);
        rd <= 1'b0;
        @(negedge ref_clk_in);
        d = rdata;
    endtask
    task automatic rd_chk(input logic [4:0] ad, input logic [15:0] e);
        logic [15:0] d;
        rd_reg(ad, d);
        check(d, e);
    endtask
    task automatic do_reset;
        rst_b_in <= 1'b0;
        repeat (5) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
    endtask
    // Runs channel zero for k + 2 cycles and returns the count advance.
    task automatic run_ch0(input logic [15:0] ctrl, input int k,
                           output logic [15:0] dlt);
        logic [15:0] st;
        wr_reg(TIC_OFS_CTRL0, ctrl);
        rd_reg(TIC_OFS_CNT0, st);
        wr_reg(TIC_OFS_START, 16'h0001);
        repeat (k) @(posedge ref_clk_in);
        wr_reg(TIC_OFS_START, 16'h0004);
        rd_reg(TIC_OFS_CNT0, dlt);
        dlt = dlt - st;
    endtask
    function automatic logic src_ok(input int s, input logic [15:0] d);
        int dv;
        dv = (s == 4) ? 32 : (1 << s);
        if (s == 5) return (d >= 16'h0008) && (d <= 16'h0009);
        if (s == 6) return (d >= 16'h0020) && (d <= 16'h0022);
        if (s == 7) return d == 16'h0000;
        return (int'(d) * dv > 66 - dv) && (int'(d) * dv < 66 + dv);
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (100000) @(posedge ref_clk_in);
        n_errors++;
        end_of_test();
    end
    initial
    begin
        do_reset();
        rd_chk(TIC_OFS_START, 16'h0000);
        rd_chk(TIC_OFS_OSC, 16'h0002);
        wr_reg(5'h1f, 16'hffff);
        wr_reg(TIC_OFS_CNT0, 16'h1234);
        rd_chk(5'h1f, 16'h0000);
        rd_chk(TIC_OFS_CNT0, 16'h0000);
        check({15'h0, irq}, 16'h0000);
        // A stop write without stop select must leave the counter running.
        wr_reg(TIC_OFS_START, 16'h0003);
        repeat (8) @(posedge ref_clk_in);
        wr_reg(TIC_OFS_START, 16'h0000);
        repeat (8) @(posedge ref_clk_in);
        wr_reg(TIC_OFS_START, 16'h000c);
        rd_chk(TIC_OFS_CNT1, 16'h0014);
        rd_chk(TIC_OFS_CNT1, 16'h0014);
        rd_chk(TIC_OFS_CNT0, 16'h0014);
        wr_reg(TIC_OFS_PINMODE, 16'h0100);
        ext_on <= 1'b1;
        for (int s = 0; s < 8; s++)
        begin
            run_ch0(16'(s), 64, v);
            check({15'h0, src_ok(s, v)}, 16'h0001);
        end
        @(posedge ref_clk_in);
        ext_on <= 1'b0;
        en_req <= 1'b0;
        run_ch0(16'h0000, 64, v);
        check(v, 16'h0000);
        @(posedge ref_clk_in);
        en_req <= 1'b1;
        for (int h = 0; h < 2; h++)
        begin
            wr_reg(TIC_OFS_OSC, 16'(h));
            @(posedge ref_clk_in);
            a = 16'(ih_cnt);
            repeat (40) @(posedge ref_clk_in);
            check(16'(ih_cnt) - a, h ? 16'h000a : 16'h0014);
        end
        wr_reg(TIC_OFS_IRQ_MASK, 16'h0010);
        run_ch0(16'h0000, 65535, v);
        check(v, 16'h0001);
        rd_chk(TIC_OFS_IRQ_STAT, 16'h0010);
        check({15'h0, irq}, 16'h0001);
        wr_reg(TIC_OFS_IRQ_STAT, 16'h0010);
        rd_chk(TIC_OFS_IRQ_STAT, 16'h0000);
        check({15'h0, irq}, 16'h0000);
        ////////////////////////////////////////////////////////////////////
        rd_reg(TIC_OFS_CNT0, c0v);
        wr_reg(TIC_OFS_PINMODE, 16'h00ff);
        wr_reg(TIC_OFS_IRQ_MASK, 16'h0155);
        for (int p = 0; p < 8; p++)
        begin
            i = (p < 4) ? p : p + 1;
            lvl[p] <= 1'b1;
            // A clear that meets the capture edge must lose to the set.
            if (p == 0)
            begin
                @(posedge ref_clk_in);
                wr_reg(TIC_OFS_IRQ_STAT, 16'h0001);
            end
            repeat (4) @(posedge ref_clk_in);
            rd_chk(5'h10 + 5'(p), (p < 4) ? c0v : 16'h0014);
            rd_chk(TIC_OFS_IRQ_STAT, 16'h0001 << i);
            check({15'h0, irq}, (16'h0155 >> i) & 16'h0001);
            wr_reg(TIC_OFS_IRQ_STAT, 16'h0001 << i);
        end
        for (int c = 0; c < 4; c++)
        begin
            wr_reg(TIC_OFS_EDGE, 16'(c) << 2);
            lvl[1] <= 1'b0;
            repeat (4) @(posedge ref_clk_in);
            v = (c == 1 || c == 2) ? 16'h0002 : 16'h0000;
            rd_chk(TIC_OFS_IRQ_STAT, v);
            wr_reg(TIC_OFS_IRQ_STAT, 16'h03ff);
            lvl[1] <= 1'b1;
            repeat (4) @(posedge ref_clk_in);
            v = (c == 0 || c == 2) ? 16'h0002 : 16'h0000;
            rd_chk(TIC_OFS_IRQ_STAT, v);
            wr_reg(TIC_OFS_IRQ_STAT, 16'h03ff);
        end
        wr_reg(TIC_OFS_PINMODE, 16'h0000);
        wr_reg(TIC_OFS_GPIO_DIR, 16'h00a5);
        wr_reg(TIC_OFS_GPIO_OUT, 16'h003c);
        lvl <= 8'h0f;
        repeat (4) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        check({8'h0, poe}, 16'h00a5);
        check({8'h0, pout}, 16'h003c);
        rd_chk(TIC_OFS_GPIO_IN, 16'h002e);
        rd_chk(TIC_OFS_IRQ_STAT, 16'h0000);
        wr_reg(TIC_OFS_PINMODE, 16'h0106);
        @(negedge ref_clk_in);
        check({8'h0, poe}, 16'h00a0);
        // Without the option strap the fast source falls back to /1.
        @(posedge ref_clk_in);
        opt <= 1'b0;
        do_reset();
        rd_chk(TIC_OFS_OSC, 16'h0000);
        run_ch0(16'h0006, 64, v);
        check(v, 16'h0042);
        end_of_test();
    end
endmodule
`default_nettype wire
